// >>> hw/snsi2c_slave.sv
// Notes on behaviour
// [RL1] Select pin high enables this slave
// [RL2] Address is 101110 plus strap bit
// [RL3] Strap high 1011101b, low 1011100b
// [RL4] SDA fall with SCL high starts
// [RL5] Seven address bits, then direction bit
// [RL6] SDA rise with SCL high stops
// [RL7] Acknowledge held low through SCL high
// [RL8] Acknowledge every received byte
// [RL9] Sub-address: index plus increment flag
// [RL10] Increment index after each data byte
// [RL11] Write bytes stored at addressed register
// [RL12] Read uses repeated start, direction one
// [RL13] Drive bytes until master not acknowledges
// [RL14] Eight bits, MSB first, unlimited count
// [RL15] Receiver may stretch; we never stall
// [RL16] Unmatched address left unacknowledged
// [RL17] Serves standard and fast mode rates
// [RL18] First byte B8h/B9h/BAh/BBh by strap
// [RL19] Bus logic independent of measurement supply
// [RL20] Auto-increment read wraps 2Ah to 28h
// [RL21] Ignore bytes after mismatch until start
`timescale 1ns/1ps
module snsi2c_slave #(
  parameter int IDX_W = snsi2c_pkg::IDX_W
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             if_select,
  input  wire logic             address_strap_pin,
  input  wire logic             serial_port_clock,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n,
  output logic                  reg_wr_q,
  output logic                  reg_rd_q,
  output logic [IDX_W-1:0]      reg_idx_q,
  output logic [7:0]            reg_wdata_q,
  input  wire logic [7:0]       reg_rdata,
  output logic                  bus_busy_q
);
  initial begin
    if (IDX_W != snsi2c_pkg::IDX_W) $error("IDX_W must be 7");
    if (snsi2c_pkg::BUS_CYC_MIN < 8) $error("Core clock too slow for bus"); // see [RL17]
  end

  snsi2c_pins_if pins ();

  // Bus front end needs only the core clock, not the measurement supply
  snsi2c_sync u_sync ( // see [RL19]
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .scl_i    (serial_port_clock),
    .sda_i    (sda_i),
    .pins     (pins)
  );

  snsi2c_pkg::snsi2c_state_t fsm_q;
  snsi2c_pkg::snsi2c_state_t ret_q;
  logic [2:0]        bit_q;
  logic [7:0]        shf_q;
  logic              sel_s0_q;
  logic              sel_q;
  logic              strap_s0_q;
  logic              strap_q;
  logic              inc_q;
  logic              sub_done_q;
  logic              drive_low_q;
  logic              rd_dir_q;
  logic [7:0]        rx_byte;

  // Next index, wrapping inside the pressure window while incrementing
  function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx);
    if (idx == snsi2c_pkg::PRESS_LAST)
      next_idx = snsi2c_pkg::PRESS_FIRST; // see [RL20]
    else
      next_idx = idx + 7'h01; // see [RL10]
  endfunction

  assign rx_byte = {shf_q[6:0], pins.sda_lvl}; // see [RL14]

  // Select and strap pins are external levels, synchronised
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_s0_q   <= 1'b0;
      sel_q      <= 1'b0;
      strap_s0_q <= 1'b0;
      strap_q    <= 1'b0;
    end else begin
      sel_s0_q   <= if_select;
      sel_q      <= sel_s0_q; // see [RL1]
      strap_s0_q <= address_strap_pin;
      strap_q    <= strap_s0_q; // see [RL3]
    end
  end

  // Bus busy between start and stop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_busy_q <= 1'b0;
    end else if (!sel_q || pins.stop_det) begin
      bus_busy_q <= 1'b0; // see [RL6]
    end else if (pins.start_det) begin
      bus_busy_q <= 1'b1; // see [RL4]
    end
  end

  // Protocol engine: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fsm_q       <= snsi2c_pkg::SNSI2C_IDLE;
      ret_q       <= snsi2c_pkg::SNSI2C_IDLE;
      bit_q       <= 3'h0;
      shf_q       <= 8'h00;
      inc_q       <= 1'b0;
      sub_done_q  <= 1'b0;
      drive_low_q <= 1'b0;
      rd_dir_q    <= 1'b0;
      reg_idx_q   <= '0;
      reg_wdata_q <= 8'h00;
      reg_wr_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      if (!sel_q || pins.stop_det) begin
        fsm_q       <= snsi2c_pkg::SNSI2C_IDLE; // see [RL1]
        drive_low_q <= 1'b0;
        sub_done_q  <= 1'b0;
      end else if (pins.start_det) begin
        fsm_q       <= snsi2c_pkg::SNSI2C_ADDR; // see [RL12]
        bit_q       <= 3'h0;
        drive_low_q <= 1'b0;
      end else begin
        unique case (fsm_q)
          snsi2c_pkg::SNSI2C_IDLE,
          snsi2c_pkg::SNSI2C_SKIP: begin
            drive_low_q <= 1'b0; // see [RL21]
          end
          snsi2c_pkg::SNSI2C_ADDR,
          snsi2c_pkg::SNSI2C_SUB,
          snsi2c_pkg::SNSI2C_WDAT: begin
            if (pins.scl_rise) begin
              shf_q <= rx_byte;
              bit_q <= bit_q + 3'h1;
            end
            if (pins.scl_fall && bit_q == 3'h0 && fsm_q != snsi2c_pkg::SNSI2C_ADDR) begin
              drive_low_q <= 1'b0;
            end
            if (pins.scl_rise && bit_q == snsi2c_pkg::BIT_LAST) begin
              unique case (fsm_q)
                snsi2c_pkg::SNSI2C_ADDR: begin
                  if (rx_byte[7:1] == {snsi2c_pkg::ADDR_HIGH, strap_q}) begin // see [RL2]
                    rd_dir_q <= rx_byte[0]; // see [RL5]
                    fsm_q    <= snsi2c_pkg::SNSI2C_ACK;
                    ret_q    <= rx_byte[0] ? snsi2c_pkg::SNSI2C_RDAT
                                           : snsi2c_pkg::SNSI2C_SUB; // see [RL18]
                  end else begin
                    fsm_q <= snsi2c_pkg::SNSI2C_SKIP; // see [RL16]
                  end
                end
                snsi2c_pkg::SNSI2C_SUB: begin
                  reg_idx_q  <= rx_byte[IDX_W-1:0]; // see [RL9]
                  inc_q      <= rx_byte[snsi2c_pkg::SUB_INC_BIT];
                  sub_done_q <= 1'b1;
                  fsm_q      <= snsi2c_pkg::SNSI2C_ACK;
                  ret_q      <= snsi2c_pkg::SNSI2C_WDAT;
                end
                default: begin
                  reg_wdata_q <= rx_byte;
                  reg_wr_q    <= 1'b1; // see [RL11]
                  fsm_q       <= snsi2c_pkg::SNSI2C_ACK;
                  ret_q       <= snsi2c_pkg::SNSI2C_WDAT;
                end
              endcase
            end
          end
          snsi2c_pkg::SNSI2C_ACK: begin
            // Pull low after the eighth falling edge, release after the ninth
            if (pins.scl_fall && !drive_low_q) begin
              drive_low_q <= 1'b1; // see [RL8]
            end else if (pins.scl_fall && drive_low_q) begin
              bit_q <= 3'h0; // see [RL7]
              if (ret_q == snsi2c_pkg::SNSI2C_RDAT) begin
                shf_q       <= reg_rdata;
                reg_rd_q    <= 1'b1; // see [RL13]
                drive_low_q <= ~reg_rdata[7];
              end else begin
                drive_low_q <= 1'b0;
              end
              fsm_q <= ret_q;
            end
          end
          snsi2c_pkg::SNSI2C_RDAT: begin
            // Shift out on falling edges, MSB first
            if (pins.scl_fall) begin
              if (bit_q == snsi2c_pkg::BIT_LAST) begin
                drive_low_q <= 1'b0; // see [RL7]
                fsm_q       <= snsi2c_pkg::SNSI2C_MACK;
                if (inc_q) reg_idx_q <= next_idx(reg_idx_q); // see [RL10]
              end else begin
                drive_low_q <= ~shf_q[3'h6 - bit_q]; // see [RL14]
                bit_q       <= bit_q + 3'h1;
              end
            end
          end
          snsi2c_pkg::SNSI2C_MACK: begin
            // Master acknowledge asks for one more byte
            if (pins.scl_rise) begin
              fsm_q <= pins.sda_lvl ? snsi2c_pkg::SNSI2C_SKIP
                                    : snsi2c_pkg::SNSI2C_ACK; // see [RL13]
              ret_q <= snsi2c_pkg::SNSI2C_RDAT;
              // Only shadow a master acknowledge; a high SDA must stay released
              drive_low_q <= !pins.sda_lvl;
            end
          end
        endcase
        // Increment after each written data byte has been stored
        if (reg_wr_q && inc_q) begin
          reg_idx_q <= next_idx(reg_idx_q); // see [RL10]
        end
      end
    end
  end

  // SDA drive from a flip-flop; enable low means driving low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_n <= 1'b1;
      sda_o    <= 1'b0;
    end else begin
      sda_o    <= 1'b0; // see [RL15]
      sda_oe_n <= ~(drive_low_q && sel_q); // see [RL16]
    end
  end

  // Acknowledge kept low while SCL is high
  a_ack_stable: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL7]
    (fsm_q == snsi2c_pkg::SNSI2C_ACK && drive_low_q && pins.scl_lvl && !pins.stop_det
     && !pins.start_det) |=> drive_low_q)
    else $error("Acknowledge released during SCL high");

  a_bad_addr_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL21]
    (fsm_q == snsi2c_pkg::SNSI2C_SKIP) |=> ##1 sda_oe_n)
    else $error("Bus driven after address mismatch");

  a_stop_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL6]
    pins.stop_det |=> (fsm_q == snsi2c_pkg::SNSI2C_IDLE && !bus_busy_q))
    else $error("Stop did not end transfer");

  a_start_busy: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL4]
    (pins.start_det && sel_q && !pins.stop_det)
      |=> (bus_busy_q && fsm_q == snsi2c_pkg::SNSI2C_ADDR))
    else $error("Start not taken");

  a_wrap_idx: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL20]
    (reg_wr_q && inc_q && reg_idx_q == snsi2c_pkg::PRESS_LAST && !pins.stop_det
     && !pins.start_det && sel_q) |=> reg_idx_q == snsi2c_pkg::PRESS_FIRST)
    else $error("Index did not wrap");

  a_inc_idx: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL10]
    (reg_wr_q && inc_q && reg_idx_q != snsi2c_pkg::PRESS_LAST && sel_q && !pins.stop_det
     && !pins.start_det) |=> reg_idx_q == $past(reg_idx_q) + 7'h01)
    else $error("Index did not advance");

  a_no_inc_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL9]
    (reg_wr_q && !inc_q) |=> $stable(reg_idx_q))
    else $error("Index moved without increment flag");

  a_sel_off_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL1]
    !sel_q |=> sda_oe_n)
    else $error("Slave drove bus while deselected");

  a_wr_after_ack: assert property (@(posedge core_clk) disable iff (!arst_n) // see [RL11]
    reg_wr_q |-> fsm_q == snsi2c_pkg::SNSI2C_ACK)
    else $error("Write strobe outside acknowledge");
endmodule

// >>> hw/snsi2c_pkg.sv
package snsi2c_pkg;
  // Fixed upper six bits of the slave address
  localparam logic [5:0] ADDR_HIGH   = 6'h2E;
  // Register index width and the byte width on the wire
  localparam int         IDX_W       = 7;
  localparam int         BYTE_W      = 8;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  // Position of the auto-increment flag in the sub-address byte
  localparam int         SUB_INC_BIT = 7;
  // Pressure output window that wraps during auto-increment
  localparam logic [6:0] PRESS_FIRST = 7'h28;
  localparam logic [6:0] PRESS_LAST  = 7'h2A;
  // Core clock and the fastest bus clock served
  localparam int         CORE_HZ     = 100000000;
  localparam int         BUS_MAX_HZ  = 400000;
  localparam int         BUS_CYC_MIN = CORE_HZ / BUS_MAX_HZ;

  typedef enum logic [2:0] {
    SNSI2C_IDLE = 3'b000,
    SNSI2C_ADDR = 3'b001,
    SNSI2C_SUB  = 3'b010,
    SNSI2C_WDAT = 3'b011,
    SNSI2C_RDAT = 3'b100,
    SNSI2C_ACK  = 3'b101,
    SNSI2C_MACK = 3'b110,
    SNSI2C_SKIP = 3'b111
  } snsi2c_state_t;
endpackage

// >>> hw/snsi2c_pins_if.sv
`timescale 1ns/1ps
interface snsi2c_pins_if;
  logic scl_rise;
  logic scl_fall;
  logic scl_lvl;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  modport sync (output scl_rise, scl_fall, scl_lvl, sda_lvl, start_det, stop_det);
  modport core (input scl_rise, scl_fall, scl_lvl, sda_lvl, start_det, stop_det);
endinterface

// >>> hw/snsi2c_sync.sv
`timescale 1ns/1ps
module snsi2c_sync (
  input  wire logic   core_clk,
  input  wire logic   arst_n,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  snsi2c_pins_if.sync pins
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_d1_q;
  logic       sda_d1_q;

  // Two-stage synchronisers, then one stage for edge finding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_q  <= 2'h3;
      sda_s_q  <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s_q  <= {scl_s_q[0], scl_i};
      sda_s_q  <= {sda_s_q[0], sda_i};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  // Edge and condition decode on synchronised levels only
  assign pins.scl_lvl   = scl_s_q[1];
  assign pins.sda_lvl   = sda_s_q[1];
  assign pins.scl_rise  = scl_s_q[1] & ~scl_d1_q;
  assign pins.scl_fall  = ~scl_s_q[1] & scl_d1_q;
  assign pins.start_det = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1]; // see [RL4]
  assign pins.stop_det  = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1]; // see [RL6]
endmodule

// >>> bench/snsi2c_master.sv
`timescale 1ns/1ps
module snsi2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  // Quarter of the 125 ns bus clock period
  localparam realtime Q = 31.25;
  // Idle bus: both lines released, clock standing still high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_low = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop: data rises while clock is high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask
  // One clock pulse; data set while clock is low, sampled mid high
  task automatic xbit(input logic b, output logic s);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda_wire;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Byte out, then release the line for the slave's answer
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(d[i], s);
    xbit(1'b1, ack_n);
  endtask
  // Byte in, then acknowledge unless it is the last one
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(last, s);
  endtask
endmodule

// >>> bench/snsi2c_slave_bench.sv
`timescale 1ns/1ps
module snsi2c_slave_bench;
  logic        core_clk;
  logic        arst_n;
  logic        if_select;
  logic        address_strap_pin;
  logic        scl;
  logic        m_low;
  logic        sda_w;
  logic        sda_o;
  logic        sda_oe_n;
  logic        reg_wr_q;
  logic        reg_rd_q;
  logic        bus_busy_q;
  logic [6:0]  reg_idx_q;
  logic [7:0]  reg_wdata_q;
  logic [7:0]  reg_rdata;
  logic [7:0]  regs [128];
  logic [14:0] wq [$];
  logic [6:0]  rq [$];
  int          n_errors;
  int          n_compared;
  int          seed;
  int          cyc;

  // Open-drain data line with pull-up
  assign sda_w = ~(m_low | ~(sda_oe_n | sda_o));
  // Register contents at the slave's index
  assign reg_rdata = regs[reg_idx_q];

  snsi2c_slave i_snsi2c_slave (
    .core_clk, .arst_n, .if_select, .address_strap_pin,
    .serial_port_clock(scl), .sda_i(sda_w), .sda_o, .sda_oe_n,
    .reg_wr_q, .reg_rd_q, .reg_idx_q, .reg_wdata_q, .reg_rdata, .bus_busy_q
  );
  snsi2c_master i_snsi2c_master (.scl(scl), .sda_low(m_low), .sda_wire(sda_w));

  // Core clock, 10 ns
  always #5 core_clk = ~core_clk;

  task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Register-side pulses matched against the oldest note
  always @(posedge core_clk) begin
    if (reg_wr_q === 1'b1)
      cmp("write", wq.size() ? wq.pop_front() : 16'hFFFF, {reg_idx_q, reg_wdata_q});
    if (reg_rd_q === 1'b1)
      cmp("read index", rq.size() ? rq.pop_front() : 16'hFFFF, reg_idx_q);
  end

  // Cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] run length expected 20000 seen more");
      give_verdict();
    end
  end

  function automatic logic [6:0] nxt(input logic [7:0] sub, input logic [6:0] ix);
    return !sub[7] ? ix : (ix == 7'h2A) ? 7'h28 : ix + 7'h01;
  endfunction

  task automatic set_in(input logic sel, input logic s);
    @(posedge core_clk);
    if_select <= sel;
    address_strap_pin <= s;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic wb(input logic [7:0] d, input logic nak);
    logic a;
    i_snsi2c_master.wbyte(d, a);
    cmp("ack", nak, a);
  endtask

  task automatic wr(input logic [7:0] sub, input int n);
    logic [6:0] ix;
    logic [7:0] d;
    ix = sub[6:0];
    i_snsi2c_master.start();
    wb(8'hB8 | {address_strap_pin, 1'b0}, 1'b0);
    wb(sub, 1'b0);
    cmp("busy", 1, bus_busy_q);
    repeat (n) begin
      d = $random(seed);
      wq.push_back({ix, d});
      ix = nxt(sub, ix);
      wb(d, 1'b0);
    end
    i_snsi2c_master.stop();
    repeat (6) @(posedge core_clk);
    cmp("busy", 0, bus_busy_q);
    $display("test write %h done", sub);
  endtask

  task automatic rd(input logic [7:0] sub, input int n);
    logic [6:0] ix;
    logic [7:0] d;
    ix = sub[6:0];
    i_snsi2c_master.start();
    wb(8'hB8 | {address_strap_pin, 1'b0}, 1'b0);
    wb(sub, 1'b0);
    i_snsi2c_master.start();
    rq.push_back(ix);
    wb(8'hB9 | {address_strap_pin, 1'b0}, 1'b0);
    for (int k = 0; k < n; k++) begin
      if (k < n - 1) rq.push_back(nxt(sub, ix));
      i_snsi2c_master.rbyte(k == n - 1, d);
      cmp("read data", regs[ix], d);
      ix = nxt(sub, ix);
    end
    i_snsi2c_master.stop();
    $display("test read %h done", sub);
  endtask

  initial begin
    seed = 80501;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    core_clk = 1'b0;
    arst_n = 1'b0;
    if_select = 1'b1;
    address_strap_pin = 1'b0;
    foreach (regs[i]) regs[i] = $random(seed);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    wr(8'h90, 3);
    wr(8'hA9, 3);
    wr(8'h05, 2);
    rd(8'hA8, 4);
    set_in(1'b1, 1'b1);
    rd(8'h03, 2);
    wr(8'h86, 2);
    // Each address code against each strap level
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 2; c++) begin
        set_in(1'b1, s[0]);
        i_snsi2c_master.start();
        wb(8'hB8 | {c[0], 1'b0}, c != s);
        wb(8'h12, c != s);
        i_snsi2c_master.stop();
      end
    end
    $display("test address match done");
    // Deselected interface ignores its own address
    set_in(1'b0, 1'b0);
    i_snsi2c_master.start();
    wb(8'hB8, 1'b1);
    i_snsi2c_master.stop();
    $display("test deselect done");
    repeat (10) @(posedge core_clk);
    cmp("pending notes", 0, wq.size() + rq.size());
    give_verdict();
  end
endmodule
